// >>> atr_pkg.sv
// Package with the map, field layout and reset values of the trim bank.
package atr_pkg;

    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam logic [15:0] ATR_BASE_BLOCKING = 16'h0200;
    localparam logic [15:0] ATR_BASE_NONBLOCKING = 16'h0300;
    localparam logic [7:0] ATR_OFS_LIN_WDOG = 8'hF0;
    localparam logic [7:0] ATR_OFS_BG_IREF = 8'hF1;
    localparam logic [7:0] ATR_OFS_SLEEP_BG = 8'hF2;
    localparam logic [7:0] ATR_OFS_RESERVED = 8'hF3;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int ATR_LIN_TRIM_EN_BIT = 7;
    localparam int ATR_LIN_TRIM_BIT = 6;
    localparam int ATR_WDOG_TRIM_EN_BIT = 5;
    localparam int ATR_WDOG_TRIM_LSB = 0;
    localparam int ATR_BG_TRIM_EN_BIT = 7;
    localparam int ATR_BG_UP_BIT = 5;
    localparam int ATR_BG_DN_BIT = 4;
    localparam int ATR_IREF_TRIM_EN_BIT = 3;
    localparam int ATR_IREF_TRIM_LSB = 0;
    localparam int ATR_SLP_TRIM_EN_BIT = 4;
    localparam int ATR_SLP_LOCK_BIT = 3;
    localparam int ATR_SLP_TRIM_LSB = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] ATR_RST_LIN_WDOG = 8'h00;
    localparam logic [7:0] ATR_RST_BG_IREF = 8'h00;
    localparam logic [4:0] ATR_RST_SLEEP_BG = 5'h00;
    localparam logic [2:0] ATR_RST_TRIM3 = 3'h0;

endpackage : atr_pkg

// >>> atr_trim_bank.sv
// Analog trim register bank reached over the die-to-die register port.
`timescale 1ns/10ps
`default_nettype none

module atr_trim_bank (
    // Clock and resets
    input wire logic clk,
    input wire logic reset_n,
    input wire logic power_on_reset_n,
    // Register port
    input wire logic [15:0] bus_addr,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire logic bus_word,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_rvalid,
    // Mode
    input wire logic low_power,
    // Applied trim effects
    output logic lin_slope_adjust,
    output logic [2:0] wdog_trim,
    output logic bg_trim_up,
    output logic bg_trim_dn,
    output logic [2:0] iref_trim,
    output logic [2:0] sleep_bg_trim
);
    import atr_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] lin_wdog;
        logic [7:0] bg_iref;
        logic [4:0] sleep_bg;
        logic [15:0] rdata;
        logic rvalid;
        logic lin_slope;
        logic [2:0] wdog;
        logic bg_up;
        logic bg_dn;
        logic [2:0] iref;
        logic [2:0] sleep_open;
    } atr_state_t;

    // Held only by power-on reset, so a locked trim outlives reset_n.
    typedef struct packed {
        logic locked;
        logic [2:0] trim;
    } atr_lock_t;

    atr_state_t s_q;
    atr_state_t s_d;
    atr_lock_t l_q;
    atr_lock_t l_d;

    logic hit;
    logic [7:0] ofs;
    logic [7:0] ofs_hi;
    logic [7:0] ofs_lo;
    logic [7:0] byte_hi;
    logic [7:0] byte_lo;
    logic unused_low_power;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Low power has no effect on the bank on purpose.
    assign unused_low_power = low_power;

    always_comb begin
        ofs = bus_addr[7:0];
        // Both bases reach the same four bytes of the bank.
        hit = ((bus_addr[15:8] == ATR_BASE_BLOCKING[15:8]) ||
               (bus_addr[15:8] == ATR_BASE_NONBLOCKING[15:8])) &&
              (ofs >= ATR_OFS_LIN_WDOG) && (ofs <= ATR_OFS_RESERVED);
        // Word accesses pair an even byte (high) with the next one.
        ofs_hi = bus_word ? {ofs[7:1], 1'b0} : ofs;
        ofs_lo = {ofs[7:1], 1'b1};
        byte_hi = bus_word ? bus_wdata[15:8] : bus_wdata[7:0];
        byte_lo = bus_wdata[7:0];
    end

    // ****************************************************************
    // Register access
    // ****************************************************************

    function automatic logic [7:0] atr_read(input atr_state_t s,
                                            input logic [7:0] o);
        logic [7:0] r;
        r = 8'h00;
        unique case (o)
            ATR_OFS_LIN_WDOG: r = s.lin_wdog;
            ATR_OFS_BG_IREF: r = s.bg_iref;
            ATR_OFS_SLEEP_BG: r = {ATR_RST_TRIM3, s.sleep_bg};
            default: r = 8'h00;
        endcase
        return r;
    endfunction : atr_read

    function automatic atr_state_t atr_write(input atr_state_t s,
                                             input logic [7:0] o,
                                             input logic [7:0] v);
        atr_state_t n;
        n = s;
        unique case (o)
            ATR_OFS_LIN_WDOG: n.lin_wdog = v;
            ATR_OFS_BG_IREF: n.bg_iref = v;
            ATR_OFS_SLEEP_BG: begin
                if (v[ATR_SLP_TRIM_EN_BIT]) begin
                    n.sleep_bg = v[4:0];
                end else begin
                    // A write with the enable clear only drops the enable.
                    n.sleep_bg = {1'b0, s.sleep_bg[3:0]};
                end
            end
            default: n = s;
        endcase
        return n;
    endfunction : atr_write

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        l_d = l_q;
        s_d.rvalid = bus_read && hit;
        if (bus_read && hit) begin
            if (bus_word) begin
                s_d.rdata = {atr_read(s_q, ofs_hi), atr_read(s_q, ofs_lo)};
            end else begin
                s_d.rdata = {8'h00, atr_read(s_q, ofs)};
            end
        end
        if (bus_write && hit) begin
            s_d = atr_write(s_d, ofs_hi, byte_hi);
            if (bus_word) begin
                s_d = atr_write(s_d, ofs_lo, byte_lo);
            end
        end
        // Applied effects are registered from the next register value, so
        // they change on the same edge as the register and never glitch.
        s_d.lin_slope = s_d.lin_wdog[ATR_LIN_TRIM_EN_BIT] &
                        s_d.lin_wdog[ATR_LIN_TRIM_BIT];
        s_d.wdog = s_d.lin_wdog[ATR_WDOG_TRIM_EN_BIT] ?
                   s_d.lin_wdog[ATR_WDOG_TRIM_LSB +: 3] : 3'h0;
        s_d.bg_up = s_d.bg_iref[ATR_BG_TRIM_EN_BIT] &
                    s_d.bg_iref[ATR_BG_UP_BIT];
        s_d.bg_dn = s_d.bg_iref[ATR_BG_TRIM_EN_BIT] &
                    s_d.bg_iref[ATR_BG_DN_BIT];
        s_d.iref = s_d.bg_iref[ATR_IREF_TRIM_EN_BIT] ?
                   s_d.bg_iref[ATR_IREF_TRIM_LSB +: 3] : 3'h0;
        s_d.sleep_open = s_d.sleep_bg[ATR_SLP_TRIM_EN_BIT] ?
                         s_d.sleep_bg[ATR_SLP_TRIM_LSB +: 3] : 3'h0;
        // The lock follows the stored bits, not the bus: a write attempted
        // while reset_n holds the bank cleared must not lock a value that
        // was never stored.
        if (!l_q.locked && s_q.sleep_bg[ATR_SLP_TRIM_EN_BIT] &&
            s_q.sleep_bg[ATR_SLP_LOCK_BIT]) begin
            l_d.locked = 1'b1;
            l_d.trim = s_q.sleep_bg[ATR_SLP_TRIM_LSB +: 3];
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{lin_wdog: ATR_RST_LIN_WDOG, bg_iref: ATR_RST_BG_IREF,
                     sleep_bg: ATR_RST_SLEEP_BG, rdata: 16'h0000,
                     rvalid: 1'b0, lin_slope: 1'b0, wdog: 3'h0,
                     bg_up: 1'b0, bg_dn: 1'b0, iref: 3'h0,
                     sleep_open: 3'h0};
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk or negedge power_on_reset_n) begin
        if (!power_on_reset_n) begin
            l_q <= '{locked: 1'b0, trim: ATR_RST_TRIM3};
        end else begin
            l_q <= l_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign bus_rdata = s_q.rdata;
    assign bus_rvalid = s_q.rvalid;
    assign lin_slope_adjust = s_q.lin_slope;
    assign wdog_trim = s_q.wdog;
    assign bg_trim_up = s_q.bg_up;
    assign bg_trim_dn = s_q.bg_dn;
    assign iref_trim = s_q.iref;
    // The locked trim lives in the power-on domain; two flops are muxed so
    // that reset_n clears the open path without touching the lock.
    assign sleep_bg_trim = l_q.locked ? l_q.trim : s_q.sleep_open;

endmodule : atr_trim_bank

`default_nettype wire

// >>> atr_trim_bank_asserts.sv
// Checker for the trim bank register port and trim outputs.
`timescale 1ns/10ps
`default_nettype none
module atr_trim_bank_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [15:0] bus_addr,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire logic bus_word,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_rvalid,
    // Trim outputs
    input wire logic lin_slope_adjust,
    input wire logic [2:0] wdog_trim,
    input wire logic [2:0] sleep_bg_trim
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire hit = (bus_addr[15:8] == 8'h02 || bus_addr[15:8] == 8'h03) &&
        bus_addr[7:2] == 6'h3C;
    wire wrb = bus_write && !bus_word && hit;
    wire rdb = bus_read && !bus_word && hit;
    sequence s_lock;
        wrb && bus_addr[1:0] == 2'h2 && bus_wdata[4:3] == 2'h3;
    endsequence
    sequence s_rewrite;
        wrb && bus_addr[1:0] == 2'h2;
    endsequence
    a_read_answer: assert property (bus_read && hit |=> bus_rvalid) else $error("read hit without answer");
    a_miss_silent: assert property (bus_read && !hit |=> !bus_rvalid) else $error("answer to a miss");
    a_reset_clear: assert property ($rose(reset_n) |-> wdog_trim == 3'h0 && !lin_slope_adjust) else $error("trim not cleared");
    a_wdog_gate: assert property (wrb && bus_addr[1:0] == 2'h0 |=> wdog_trim == ($past(bus_wdata[5]) ? $past(bus_wdata[2:0]) : 3'h0)) else $error("watchdog trim wrong");
    a_lin_gate: assert property (wrb && bus_addr[1:0] == 2'h0 |=> lin_slope_adjust == $past(bus_wdata[7] & bus_wdata[6])) else $error("slope trim wrong");
    a_word_pair: assert property (bus_write && bus_word && hit && bus_addr[1] == 1'b0 |=> wdog_trim == ($past(bus_wdata[13]) ? $past(bus_wdata[10:8]) : 3'h0)) else $error("word byte order wrong");
    a_rsvd_zero: assert property (rdb && bus_addr[1:0] == 2'h3 |=> bus_rdata == 16'h0000) else $error("reserved reads nonzero");
    a_sleep_upper: assert property (rdb && bus_addr[1:0] == 2'h2 |=> bus_rdata[15:5] == 11'h000) else $error("upper sleep bits set");
    a_lock_hold: assert property (s_lock ##[1:8] s_rewrite |=> $stable(sleep_bg_trim)) else $error("locked trim moved");
endmodule : atr_trim_bank_asserts
bind atr_trim_bank atr_trim_bank_asserts i_chk (.clk, .reset_n, .bus_addr,
    .bus_write, .bus_read, .bus_word, .bus_wdata, .bus_rdata, .bus_rvalid,
    .lin_slope_adjust, .wdog_trim, .sleep_bg_trim);
`default_nettype wire

// >>> atr_host_model.sv
// Host model that masters the register port and loads factory trim.
`timescale 1ns/10ps
`default_nettype none
module atr_host_model #(
    parameter logic [31:0] INFO_ROW = 32'hE5BA1D00
) (
    // Clock
    input wire logic clk,
    // Register port
    output logic [15:0] bus_addr,
    output logic bus_write,
    output logic bus_read,
    output logic bus_word,
    output logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_rvalid
);
    logic row_readable = 1'b0;
    initial {bus_addr, bus_write, bus_read, bus_word, bus_wdata} = '0;
    task automatic xfer(input logic w, word, input logic [15:0] a, d,
                        output logic [15:0] q, output logic v);
        @(negedge clk);
        {bus_addr, bus_word, bus_wdata, bus_write, bus_read} = {a, word, d, w, !w};
        @(negedge clk);
        // The answer stands one cycle only, so it is taken before release.
        {q, v} = {bus_rdata, bus_rvalid};
        // Released data shows the inverse so a stale value never looks valid.
        {bus_write, bus_read, bus_wdata} = {2'b00, ~d};
    endtask : xfer
    task automatic load(output logic [15:0] q, output logic v);
        logic [31:0] row;
        row_readable = 1'b1;
        // A closed information row reads as erased.
        row = row_readable ? INFO_ROW : 32'h0000_0000;
        xfer(1'b1, 1'b1, 16'h02F0, row[31:16], q, v);
        // The lock bit is masked so a bad power-up cannot lock defaults.
        xfer(1'b1, 1'b1, 16'h02F2, row[15:0] & 16'hF7FF, q, v);
    endtask : load
endmodule : atr_host_model
`default_nettype wire

// >>> atr_trim_bank_tb.sv
// Self-checking testbench for the trim bank.
`timescale 1ns/10ps
`default_nettype none
module atr_trim_bank_tb;
    import atr_pkg::*;
    logic clk = 0, reset_n = 0, power_on_reset_n = 0, low_power = 0;
    logic [15:0] bus_addr, bus_wdata, bus_rdata, q;
    logic bus_write, bus_read, bus_word, bus_rvalid, v;
    logic lin_slope_adjust, bg_trim_up, bg_trim_dn;
    logic [2:0] wdog_trim, iref_trim, sleep_bg_trim;
    int miscompares = 0, tests_run = 0;
    always #50 clk = ~clk;
    atr_trim_bank i_dut (.clk, .reset_n, .power_on_reset_n, .bus_addr,
        .bus_write, .bus_read, .bus_word, .bus_wdata, .bus_rdata, .bus_rvalid,
        .low_power, .lin_slope_adjust, .wdog_trim, .bg_trim_up, .bg_trim_dn,
        .iref_trim, .sleep_bg_trim);
    atr_host_model i_host (.clk, .bus_addr, .bus_write, .bus_read, .bus_word,
        .bus_wdata, .bus_rdata, .bus_rvalid);
    task automatic chk(input logic [15:0] s, e, input string n);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, d);
        i_host.xfer(1'b1, 1'b0, a, d, q, v);
    endtask : wr
    task automatic rd(input logic [15:0] a, e);
        i_host.xfer(1'b0, 1'b0, a, 16'h0000, q, v);
        chk({15'h0, v}, 16'h0001, "rvalid");
        chk(q, e, "rdata");
    endtask : rd
    task automatic t_defaults;
        for (int i = 0; i < 4; i++) rd(16'h02F0 + 16'(i), 16'h0000);
    endtask : t_defaults
    task automatic t_load;
        i_host.load(q, v);
        chk({lin_slope_adjust, wdog_trim, bg_trim_up, bg_trim_dn, iref_trim,
            sleep_bg_trim}, 16'h0DD5, "trims");
        i_host.xfer(1'b0, 1'b1, 16'h03F0, 16'h0000, q, v);
        chk(q, 16'hE5BA, "word read");
        rd(16'h02F2, 16'h0015);
    endtask : t_load
    task automatic t_gates;
        wr(16'h02F0, 16'h0047);
        wr(16'h02F2, 16'h0007);
        chk({lin_slope_adjust, wdog_trim, sleep_bg_trim}, 16'h0000, "gated");
    endtask : t_gates
    task automatic t_lock;
        wr(16'h02F2, 16'h00FF);
        rd(16'h02F2, 16'h001F);
        wr(16'h02F2, 16'h0012);
        chk({13'h0000, sleep_bg_trim}, 16'h0007, "locked");
        low_power = 1'b1;
        rd(16'h02F0, 16'h0047);
        wr(16'h02F3, 16'h00FF);
        rd(16'h02F3, 16'h0000);
        i_host.xfer(1'b0, 1'b0, 16'h02EF, 16'h0000, q, v);
        chk({15'h0, v}, 16'h0000, "miss");
        @(negedge clk) reset_n = 0;
        @(negedge clk) reset_n = 1;
        rd(16'h02F2, 16'h0000);
        chk({13'h0000, sleep_bg_trim}, 16'h0007, "after reset");
        @(negedge clk) power_on_reset_n = 0;
        @(negedge clk) power_on_reset_n = 1;
        chk({13'h0000, sleep_bg_trim}, 16'h0000, "after power on");
    endtask : t_lock
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (2) @(negedge clk);
        {reset_n, power_on_reset_n} = 2'b11;
        t_defaults();
        t_load();
        t_gates();
        t_lock();
        report_and_stop();
    end
    // The run needs some 40 cycles; the limit leaves wide margin.
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
endmodule : atr_trim_bank_tb
`default_nettype wire
